/* design/fsc_pkg.sv */
// Package of offsets, field positions, reset values and codes for the
// flash security and configuration register bank.
// Assumes a byte-wide register port with a 5-bit address.
package fsc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [4:0] OFS_SECURITY = 5'h01;
  localparam logic [4:0] OFS_TEST_CTRL = 5'h02;
  localparam logic [4:0] OFS_CONFIG = 5'h03;
  localparam logic [4:0] OFS_BANK_FIRST = 5'h04;
  localparam logic [4:0] OFS_BANK_LAST = 5'h0b;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h11;
  // ==========================================================
  // Field positions
  localparam int PERMIT_HI = 7;
  localparam int PERMIT_LO = 6;
  localparam int LOCK_HI = 1;
  localparam int LOCK_LO = 0;
  localparam int BCAST_BIT = 4;
  localparam int BE_IE_BIT = 7;
  localparam int DONE_IE_BIT = 6;
  localparam int KEY_MODE_BIT = 5;
  localparam int BANK_BIT = 0;
  // Interrupt status bits
  localparam int EV_BUF_EMPTY = 0;
  localparam int EV_ALL_DONE = 1;
  localparam int EV_UNLOCK = 2;
  localparam int EV_LOADED = 3;
  // ==========================================================
  // Codes and reset values
  localparam logic [1:0] PERMIT_ON = 2'h2;
  localparam logic [1:0] LOCK_OPEN = 2'h2;
  localparam logic [15:0] NV_SECURITY_ADDR = 16'hff0f;
  localparam logic [7:0] SECURITY_RST = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] EV_ZERO = 4'h0;
  localparam logic [7:0] CFG_WR_MASK = 8'he1;
  localparam logic [7:0] TEST_WR_MASK = 8'h10;
  // ==========================================================
  // Reset-time load sequence
  typedef enum logic [1:0] {
    FSC_LOAD_REQ = 2'b00,
    FSC_LOAD_WAIT = 2'b01,
    FSC_RUN = 2'b11
  } fsc_state_t;
endpackage

/* design/fsc_regs.sv */
// Unbanked security, test and configuration registers of a flash
// controller, plus two banks of eight banked register bytes.
// Assumes a same-clock register port, a nonvolatile reader that answers
// one request, and command logic that supplies the buffer flags.
//
// Contract
// - Security byte is fully readable; software writes to it are ignored.
// - Security byte loads from nonvolatile location ff0f during reset sequence.
// - Backdoor key access is enabled only when permit field equals 10.
// - Successful backdoor unlock forces lock state to read 10.
// - Normal mode: test register reads zero and ignores writes.
// - Broadcast write bit 4 is writable only in special mode.
// - Broadcast set writes all banks; clear writes only the chosen bank.
// - Config bits 7,6,5,0 read/write; other bits read zero.
// - Key write mode bit is writable only when permit equals 10.
// - Buffer-empty enable set requests interrupt while buffer-empty flag set.
// - Done enable set requests interrupt while all-done flag set.
// - Key write mode clear: array writes start command sequences.
// - Key write mode set: array writes are keys; array reads invalid.
// - Bank choice 0 selects block 0 set, 1 selects block 1.
// - Offsets 04 to 0b exist per block, routed by bank choice.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module fsc_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic special_mode_pin,
  output logic nv_rd_req,
  output logic [15:0] nv_rd_addr,
  input wire logic nv_rd_valid,
  input wire logic [7:0] nv_rd_data,
  output logic load_done,
  input wire logic backdoor_unlock,
  output logic key_access_enabled,
  output logic part_unsecured,
  input wire logic array_wr,
  input wire logic array_rd,
  output logic array_cmd_start,
  output logic array_key_write,
  output logic array_rdata_valid,
  output logic bank_choice,
  output logic broadcast_write,
  output logic [15:0] bank0_regs_flat,
  output logic [15:0] bank1_regs_flat,
  input wire logic buffer_empty_flag,
  input wire logic all_done_flag,
  output logic buffer_empty_irq,
  output logic done_irq,
  output logic irq
);

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a == o);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // ==========================================================
  // Register access decode
  logic bank_hit;
  logic [2:0] bank_idx;
  logic wr_test;
  logic wr_cfg;
  logic wr_bank;
  logic wr_mask;
  logic rd_status;

  assign bank_hit = (reg_addr >= fsc_pkg::OFS_BANK_FIRST) && (reg_addr <= fsc_pkg::OFS_BANK_LAST);
  assign bank_idx = 3'(reg_addr - fsc_pkg::OFS_BANK_FIRST);
  assign wr_test = reg_wr && hit(reg_addr, fsc_pkg::OFS_TEST_CTRL);
  assign wr_cfg = reg_wr && hit(reg_addr, fsc_pkg::OFS_CONFIG);
  assign wr_bank = reg_wr && bank_hit;
  assign wr_mask = reg_wr && hit(reg_addr, fsc_pkg::OFS_IRQ_MASK);
  assign rd_status = reg_rd && hit(reg_addr, fsc_pkg::OFS_IRQ_STATUS);

  // ==========================================================
  // Special mode pin synchroniser
  logic mode_s1_q;
  logic mode_s1_d;
  logic mode_s2_q;
  logic mode_s2_d;

  always_comb begin
    mode_s1_d = special_mode_pin;
    mode_s2_d = mode_s1_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      mode_s1_q <= mode_s1_d;
      mode_s2_q <= mode_s2_d;
    end
  end

  // ==========================================================
  // Reset-time load of the security byte
  fsc_pkg::fsc_state_t state_q;
  fsc_pkg::fsc_state_t state_d;
  logic [7:0] sec_q;
  logic [7:0] sec_d;
  logic unlocked_q;
  logic unlocked_d;

  always_comb begin
    state_d = state_q;
    sec_d = sec_q;
    case (state_q)
      fsc_pkg::FSC_LOAD_REQ: begin
        state_d = fsc_pkg::FSC_LOAD_WAIT;
      end
      fsc_pkg::FSC_LOAD_WAIT: begin
        if (nv_rd_valid) begin
          sec_d = nv_rd_data;
          state_d = fsc_pkg::FSC_RUN;
        end
      end
      fsc_pkg::FSC_RUN: begin
        state_d = fsc_pkg::FSC_RUN;
      end
      default: begin
        state_d = fsc_pkg::FSC_LOAD_REQ;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= fsc_pkg::FSC_LOAD_REQ;
      sec_q <= fsc_pkg::SECURITY_RST;
    end else begin
      state_q <= state_d;
      sec_q <= sec_d;
    end
  end

  assign nv_rd_req = (state_q == fsc_pkg::FSC_LOAD_REQ);
  assign nv_rd_addr = fsc_pkg::NV_SECURITY_ADDR;
  assign load_done = (state_q == fsc_pkg::FSC_RUN);

  // ==========================================================
  // Backdoor unlock latch, held until the next reset
  always_comb begin
    unlocked_d = unlocked_q;
    if (load_done && backdoor_unlock && key_access_enabled) begin
      unlocked_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      unlocked_q <= 1'b0;
    end else begin
      unlocked_q <= unlocked_d;
    end
  end

  // Security view: lock field forced open after a backdoor unlock
  logic [7:0] sec_view;
  always_comb begin
    sec_view = sec_q;
    if (unlocked_q) begin
      sec_view[fsc_pkg::LOCK_HI:fsc_pkg::LOCK_LO] = fsc_pkg::LOCK_OPEN;
    end
  end

  assign key_access_enabled =
    (sec_q[fsc_pkg::PERMIT_HI:fsc_pkg::PERMIT_LO] == fsc_pkg::PERMIT_ON);
  assign part_unsecured =
    (sec_view[fsc_pkg::LOCK_HI:fsc_pkg::LOCK_LO] == fsc_pkg::LOCK_OPEN);

  // ==========================================================
  // Test control and configuration registers
  logic [7:0] test_q;
  logic [7:0] test_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] cfg_mask;

  always_comb begin
    test_d = test_q;
    if (wr_test && mode_s2_q) begin
      test_d = merge(test_q, reg_wdata, fsc_pkg::TEST_WR_MASK);
    end
    if (!mode_s2_q) begin
      test_d = fsc_pkg::BYTE_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      test_q <= fsc_pkg::BYTE_ZERO;
    end else begin
      test_q <= test_d;
    end
  end

  always_comb begin
    cfg_mask = fsc_pkg::CFG_WR_MASK;
    if (!key_access_enabled) begin
      cfg_mask[fsc_pkg::KEY_MODE_BIT] = 1'b0;
    end
    cfg_d = cfg_q;
    if (wr_cfg) begin
      cfg_d = merge(cfg_q, reg_wdata, cfg_mask);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= fsc_pkg::BYTE_ZERO;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign broadcast_write = test_q[fsc_pkg::BCAST_BIT];
  assign bank_choice = cfg_q[fsc_pkg::BANK_BIT];

  // ==========================================================
  // Banked registers, one set per array block
  logic [7:0] bank0_q [8];
  logic [7:0] bank0_d [8];
  logic [7:0] bank1_q [8];
  logic [7:0] bank1_d [8];
  logic [7:0] bank_rdata;

  always_comb begin
    bank0_d = bank0_q;
    bank1_d = bank1_q;
    if (wr_bank) begin
      if (broadcast_write || !bank_choice) begin
        bank0_d[bank_idx] = reg_wdata;
      end
      if (broadcast_write || bank_choice) begin
        bank1_d[bank_idx] = reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        bank0_q[i] <= fsc_pkg::BYTE_ZERO;
        bank1_q[i] <= fsc_pkg::BYTE_ZERO;
      end
    end else begin
      bank0_q <= bank0_d;
      bank1_q <= bank1_d;
    end
  end

  assign bank0_regs_flat = {bank0_q[1], bank0_q[0]};
  assign bank1_regs_flat = {bank1_q[1], bank1_q[0]};

  always_comb begin
    bank_rdata = bank0_q[bank_idx];
    if (bank_choice) begin
      bank_rdata = bank1_q[bank_idx];
    end
  end

  // ==========================================================
  // Flash array access steering
  assign array_cmd_start = array_wr && !cfg_q[fsc_pkg::KEY_MODE_BIT];
  assign array_key_write = array_wr && cfg_q[fsc_pkg::KEY_MODE_BIT];
  assign array_rdata_valid = array_rd && !cfg_q[fsc_pkg::KEY_MODE_BIT];

  // ==========================================================
  // Flash interrupt requests
  assign buffer_empty_irq = buffer_empty_flag && cfg_q[fsc_pkg::BE_IE_BIT];
  assign done_irq = all_done_flag && cfg_q[fsc_pkg::DONE_IE_BIT];

  // ==========================================================
  // Event status, mask and interrupt line
  logic [3:0] ev_q;
  logic [3:0] ev_d;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic be_prev_q;
  logic be_prev_d;
  logic done_prev_q;
  logic done_prev_d;
  logic load_prev_q;
  logic load_prev_d;
  logic [3:0] ev_set;

  always_comb begin
    ev_set = fsc_pkg::EV_ZERO;
    ev_set[fsc_pkg::EV_BUF_EMPTY] = buffer_empty_flag && !be_prev_q;
    ev_set[fsc_pkg::EV_ALL_DONE] = all_done_flag && !done_prev_q;
    ev_set[fsc_pkg::EV_UNLOCK] = unlocked_d && !unlocked_q;
    ev_set[fsc_pkg::EV_LOADED] = load_done && !load_prev_q;
  end

  always_comb begin
    be_prev_d = buffer_empty_flag;
    done_prev_d = all_done_flag;
    load_prev_d = load_done;
    ev_d = ev_q;
    if (rd_status) begin
      ev_d = fsc_pkg::EV_ZERO;
    end
    ev_d = ev_d | ev_set;
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = reg_wdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_q <= fsc_pkg::EV_ZERO;
      mask_q <= fsc_pkg::EV_ZERO;
      be_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      ev_q <= ev_d;
      mask_q <= mask_d;
      be_prev_q <= be_prev_d;
      done_prev_q <= done_prev_d;
      load_prev_q <= load_prev_d;
    end
  end

  assign irq = |(ev_q & mask_q);

  // ==========================================================
  // Read data, valid in the cycle after the read strobe
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = fsc_pkg::BYTE_ZERO;
    if (reg_rd) begin
      if (hit(reg_addr, fsc_pkg::OFS_SECURITY)) begin
        rdata_d = sec_view;
      end else if (hit(reg_addr, fsc_pkg::OFS_TEST_CTRL)) begin
        rdata_d = test_q;
      end else if (hit(reg_addr, fsc_pkg::OFS_CONFIG)) begin
        rdata_d = cfg_q;
      end else if (bank_hit) begin
        rdata_d = bank_rdata;
      end else if (hit(reg_addr, fsc_pkg::OFS_IRQ_STATUS)) begin
        rdata_d = {4'h0, ev_q};
      end else if (hit(reg_addr, fsc_pkg::OFS_IRQ_MASK)) begin
        rdata_d = {4'h0, mask_q};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= fsc_pkg::BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

/* verification/fsc_regs_checker.sv */
// Assertions on the ports of the flash security and configuration bank.
// Assumes it is bound to fsc_regs and shares its single clock.
`timescale 1ns/100ps
module fsc_regs_checker (
  input logic clk,
  input logic rst,
  input logic [4:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic special_mode_pin,
  input logic nv_rd_req,
  input logic [15:0] nv_rd_addr,
  input logic nv_rd_valid,
  input logic load_done,
  input logic backdoor_unlock,
  input logic key_access_enabled,
  input logic part_unsecured,
  input logic array_wr,
  input logic array_rd,
  input logic array_cmd_start,
  input logic array_key_write,
  input logic array_rdata_valid,
  input logic bank_choice,
  input logic broadcast_write,
  input logic [15:0] bank0_regs_flat,
  input logic [15:0] bank1_regs_flat,
  input logic buffer_empty_flag,
  input logic all_done_flag,
  input logic buffer_empty_irq,
  input logic done_irq
);
  // ==========================================================
  // Sequences
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_cfg_wr;
    reg_wr && reg_addr == fsc_pkg::OFS_CONFIG;
  endsequence
  sequence s_sec_rd;
    reg_rd && reg_addr == fsc_pkg::OFS_SECURITY && !nv_rd_valid && !backdoor_unlock;
  endsequence
  // ==========================================================
  // Assertions
  AST_RDATA_IDLE: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data without a read");
  AST_KEY_FIELD: assert property (s_sec_rd |=> (reg_rdata[7:6] == 2'b10) == key_access_enabled)
    else $error("permit field and key access differ");
  AST_LOCK_FIELD: assert property (s_sec_rd |=> (reg_rdata[1:0] == 2'b10) == part_unsecured)
    else $error("lock field and unsecured differ");
  AST_UNLOCK: assert property (backdoor_unlock && key_access_enabled && load_done |=> part_unsecured [*2])
    else $error("unlock not taken");
  AST_NV_ADDR: assert property (nv_rd_req |-> nv_rd_addr == fsc_pkg::NV_SECURITY_ADDR && !load_done)
    else $error("bad load request");
  AST_TEST_NORMAL: assert property (!special_mode_pin [*5] |-> !broadcast_write)
    else $error("broadcast set in normal mode");
  AST_BCAST: assert property (reg_wr && reg_addr == fsc_pkg::OFS_BANK_FIRST && broadcast_write |=>
    bank0_regs_flat[7:0] == $past(reg_wdata) && bank1_regs_flat[7:0] == $past(reg_wdata))
    else $error("broadcast write missed a bank");
  AST_BANK_SEL: assert property (s_cfg_wr |=> {7'h00, bank_choice} == ($past(reg_wdata) & 8'h01))
    else $error("bank choice not written");
  AST_IRQ_EN: assert property (s_cfg_wr ##1 (buffer_empty_flag && all_done_flag) |->
    {buffer_empty_irq, done_irq, 6'h00} == ($past(reg_wdata) & 8'hc0))
    else $error("interrupt enable mismatch");
  AST_IRQ_FLAG: assert property ((buffer_empty_irq <= buffer_empty_flag) && (done_irq <= all_done_flag))
    else $error("request without flag");
  AST_ARRAY: assert property (array_wr && array_rd |->
    array_cmd_start == array_rdata_valid && array_cmd_start != array_key_write)
    else $error("array access mode mismatch");
endmodule
bind fsc_regs fsc_regs_checker u_chk (.*);

/* verification/fsc_regs_tb.sv */
// Self-checking bench of the flash security and configuration bank.
// Assumes fsc_regs with its checker bound and one 100 MHz clock.
`timescale 1ns/100ps
module fsc_regs_tb;
  logic clk, rst, reg_wr, reg_rd, special_mode_pin, nv_rd_req, nv_rd_valid, load_done, backdoor_unlock;
  logic key_access_enabled, part_unsecured, array_wr, array_rd, array_cmd_start, array_key_write;
  logic array_rdata_valid, bank_choice, broadcast_write, buffer_empty_flag, all_done_flag;
  logic buffer_empty_irq, done_irq, irq;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, nv_rd_data, rd_val;
  logic [15:0] nv_rd_addr, bank0_regs_flat, bank1_regs_flat;
  int error_cnt = 0;
  int tests_run = 0;
  // Rows of address, write data, read back
  logic [23:0] rows [7] = '{24'h03_ff_e1, 24'h01_00_bd, 24'h02_ff_00, 24'h0c_ff_00, 24'h04_5a_5a,
    24'h03_e0_e0, 24'h04_3c_3c};

  fsc_regs dut (.*);
  always #5 clk = ~clk;

  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  task automatic arr(input logic [7:0] exp);
    @(posedge clk);
    array_wr <= 1'b1;
    array_rd <= 1'b1;
    #1;
    chk("array", {5'h00, array_cmd_start, array_key_write, array_rdata_valid}, exp);
    @(posedge clk);
    array_wr <= 1'b0;
    array_rd <= 1'b0;
  endtask
  task automatic do_reset(input logic [7:0] nv);
    int n;
    @(posedge clk);
    rst <= 1'b1;
    nv_rd_data <= nv;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("load req", {7'h00, nv_rd_req}, 8'h01);
    @(posedge clk);
    nv_rd_valid <= 1'b1;
    @(posedge clk);
    nv_rd_valid <= 1'b0;
    n = 0;
    while (load_done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (load_done !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, special_mode_pin, nv_rd_valid, backdoor_unlock} = 5'h00;
    {array_wr, array_rd, buffer_empty_flag, all_done_flag} = 4'h0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    nv_rd_data = 8'h00;
    do_reset(8'hbd);
    chk("permit", {key_access_enabled, part_unsecured, 6'h00}, 8'h80);
    rd(fsc_pkg::OFS_IRQ_STATUS);
    chk("load event", rd_val, 8'h08);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][20:16], rows[i][15:8]);
      rd(rows[i][20:16]);
      chk("row", rd_val, rows[i][7:0]);
    end
    chk("banks", {bank0_regs_flat[7:0] ^ 8'h3c} | {bank1_regs_flat[7:0] ^ 8'h5a}, 8'h00);
    arr(8'h02);
    special_mode_pin <= 1'b1;
    repeat (4) @(posedge clk);
    wr(fsc_pkg::OFS_TEST_CTRL, 8'h10);
    rd(fsc_pkg::OFS_TEST_CTRL);
    chk("test", rd_val, 8'h10);
    wr(fsc_pkg::OFS_BANK_FIRST, 8'ha5);
    #1;
    chk("bcast", bank0_regs_flat[7:0] & bank1_regs_flat[7:0], 8'ha5);
    @(posedge clk);
    special_mode_pin <= 1'b0;
    repeat (5) @(posedge clk);
    rd(fsc_pkg::OFS_TEST_CTRL);
    chk("test normal", rd_val, 8'h00);
    wr(fsc_pkg::OFS_IRQ_MASK, 8'h0f);
    buffer_empty_flag <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("be irq", {6'h00, buffer_empty_irq, irq}, 8'h03);
    rd(fsc_pkg::OFS_IRQ_STATUS);
    chk("status be", rd_val, 8'h01);
    wr(fsc_pkg::OFS_IRQ_MASK, 8'h00);
    all_done_flag <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("done masked", {6'h00, done_irq, irq}, 8'h02);
    wr(fsc_pkg::OFS_IRQ_MASK, 8'h0f);
    @(posedge clk);
    #1;
    chk("irq", 8'(irq), 8'h01);
    rd(fsc_pkg::OFS_IRQ_STATUS);
    chk("status done", rd_val, 8'h02);
    wr(fsc_pkg::OFS_CONFIG, 8'h00);
    #1;
    chk("irq off", {6'h00, buffer_empty_irq, done_irq}, 8'h00);
    arr(8'h05);
    backdoor_unlock <= 1'b1;
    @(posedge clk);
    backdoor_unlock <= 1'b0;
    rd(fsc_pkg::OFS_SECURITY);
    chk("unlocked", rd_val, 8'hbe);
    do_reset(8'h7d);
    wr(fsc_pkg::OFS_CONFIG, 8'hff);
    rd(fsc_pkg::OFS_CONFIG);
    chk("no key mode", rd_val, 8'hc1);
    end_of_test();
  end
endmodule
